/* core/s2de_decode.v */
/*
  Stage-2 directory entry decoder: takes a fetched 64-bit entry from the
  page-walk engine and returns the next-table address, permissions and
  malformed-entry status one cycle later.
  Assumes entry_valid_i and its companions come from logic on clk_sys_i.
*/
`timescale 1ns/1ps
`include "s2de_regs.vh"

module s2de_decode
#(
  parameter HOST_ADDR_WIDTH = `S2DE_HAW_DEFAULT
)
(
  input wire clk_sys_i,
  input wire resetn_i,
  input wire entry_valid_i,
  input wire [`S2DE_ENTRY_W-1:0] stage2_dir_entry_i,
  input wire io_perm_en_i,
  input wire zero_len_read_support_i,
  input wire access_dirty_track_en_i,
  input wire zero_len_i,
  output reg result_valid_o,
  output reg [`S2DE_HAW_MAX-1:0] next_table_addr_o,
  output reg points_to_table_o,
  output reg large_page_flag_o,
  output reg read_ok_o,
  output reg write_ok_o,
  output reg accessed_o,
  output reg malformed_o
);

  // ==========================================
  // Field and check wires
  wire rd_ok;
  wire wr_ok;
  wire [`S2DE_HAW_MAX-1:0] addr_field;
  wire [`S2DE_HAW_MAX-1:0] rsvd_field;
  wire io_write_perm;
  wire large_page_flag;
  wire accessed_bit;
  wire rsvd_snoop;
  wire rsvd_high;
  wire rsvd_io_write;
  wire malformed;
  genvar bit_idx;

  // ==========================================
  // Next values
  reg result_valid_next;
  reg [`S2DE_HAW_MAX-1:0] next_table_addr_next;
  reg points_to_table_next;
  reg large_page_flag_next;
  reg read_ok_next;
  reg write_ok_next;
  reg accessed_next;
  reg malformed_next;

  // ==========================================
  // Entry fields
  assign io_write_perm = stage2_dir_entry_i[`S2DE_BIT_IO_WRITE];
  assign large_page_flag = stage2_dir_entry_i[`S2DE_BIT_LARGE_PAGE];
  // Tracking off: report zero so walker never relies on it
  assign accessed_bit = access_dirty_track_en_i &
    stage2_dir_entry_i[`S2DE_BIT_ACCESSED];
  assign rsvd_snoop = stage2_dir_entry_i[`S2DE_BIT_RSVD_LO];

  // ==========================================
  // Permissions
  s2de_perm u_perm
  (
    .entry_i(stage2_dir_entry_i),
    .io_perm_en_i(io_perm_en_i),
    .zero_len_read_support_i(zero_len_read_support_i),
    .zero_len_i(zero_len_i),
    .read_ok_o(rd_ok),
    .write_ok_o(wr_ok)
  );

  // ==========================================
  // Address field split
  assign addr_field[`S2DE_ADDR_LSB-1:0] = {`S2DE_ADDR_LSB{1'h0}};
  assign rsvd_field[`S2DE_ADDR_LSB-1:0] = {`S2DE_ADDR_LSB{1'h0}};
  // Per-bit split keeps host width a parameter; bits from it up to bit 51 are reserved
  generate
    for (bit_idx = `S2DE_ADDR_LSB; bit_idx < `S2DE_HAW_MAX; bit_idx = bit_idx + 1)
    begin : g_entry_bit
      if (bit_idx < HOST_ADDR_WIDTH)
      begin : g_addr
        assign addr_field[bit_idx] = stage2_dir_entry_i[bit_idx];
        assign rsvd_field[bit_idx] = 1'h0;
      end
      else
      begin : g_rsvd
        assign addr_field[bit_idx] = 1'h0;
        assign rsvd_field[bit_idx] = stage2_dir_entry_i[bit_idx];
      end
    end
  endgenerate

  // ==========================================
  // Reserved-bit check
  assign rsvd_high = |rsvd_field;
  // Bit 62 only counts as reserved in classic mode
  assign rsvd_io_write = ~io_perm_en_i & io_write_perm;
  assign malformed = rsvd_snoop | rsvd_high | rsvd_io_write;

  // ==========================================
  // Result valid
  // One pulse per entry; no back-pressure, entries may come every cycle
  always @*
  begin
    result_valid_next = entry_valid_i;
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_valid_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      result_valid_o <= result_valid_next;
    end
  end

  // ==========================================
  // Next-table address
  // Holds until the next entry so the walker may read it late
  always @*
  begin
    next_table_addr_next = next_table_addr_o;
    if (entry_valid_i)
    begin
      next_table_addr_next = addr_field;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      next_table_addr_o <= `S2DE_RST_ADDR;
    end
    else
    begin
      next_table_addr_o <= next_table_addr_next;
    end
  end

  // ==========================================
  // Table pointer flag
  // A large-page entry is not malformed; it simply points to no table
  always @*
  begin
    points_to_table_next = points_to_table_o;
    if (entry_valid_i)
    begin
      points_to_table_next = ~large_page_flag;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      points_to_table_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      points_to_table_o <= points_to_table_next;
    end
  end

  // ==========================================
  // Large-page flag
  always @*
  begin
    large_page_flag_next = large_page_flag_o;
    if (entry_valid_i)
    begin
      large_page_flag_next = large_page_flag;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      large_page_flag_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      large_page_flag_o <= large_page_flag_next;
    end
  end

  // ==========================================
  // Read permission
  // Malformed entry grants nothing
  always @*
  begin
    read_ok_next = read_ok_o;
    if (entry_valid_i)
    begin
      read_ok_next = rd_ok & ~malformed;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      read_ok_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      read_ok_o <= read_ok_next;
    end
  end

  // ==========================================
  // Write permission
  // Malformed entry grants nothing
  always @*
  begin
    write_ok_next = write_ok_o;
    if (entry_valid_i)
    begin
      write_ok_next = wr_ok & ~malformed;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      write_ok_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      write_ok_o <= write_ok_next;
    end
  end

  // ==========================================
  // Accessed flag
  always @*
  begin
    accessed_next = accessed_o;
    if (entry_valid_i)
    begin
      accessed_next = accessed_bit;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      accessed_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      accessed_o <= accessed_next;
    end
  end

  // ==========================================
  // Malformed flag
  always @*
  begin
    malformed_next = malformed_o;
    if (entry_valid_i)
    begin
      malformed_next = malformed;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      malformed_o <= `S2DE_RST_FLAG;
    end
    else
    begin
      malformed_o <= malformed_next;
    end
  end

endmodule

/* include/s2de_regs.vh */
/*
  Bit positions, widths and reset values for the stage-2 directory entry decoder.
  Assumes a 64-bit entry and a host address width no wider than 52 bits.
*/
`ifndef S2DE_REGS_VH
`define S2DE_REGS_VH

// ==========================================
// Entry layout
`define S2DE_ENTRY_W 64
`define S2DE_HAW_DEFAULT 46
`define S2DE_HAW_MAX 52
`define S2DE_BIT_IO_WRITE 62
`define S2DE_BIT_IO_READ 61
`define S2DE_BIT_RSVD_LO 11
`define S2DE_BIT_ACCESSED 8
`define S2DE_BIT_LARGE_PAGE 7
`define S2DE_BIT_WRITE 1
`define S2DE_BIT_READ 0
`define S2DE_ADDR_LSB 12

// ==========================================
// Reset values
`define S2DE_RST_ADDR 52'h0_0000_0000_0000
`define S2DE_RST_FLAG 1'h0

`endif

/* core/s2de_perm.v */
/*
  Permission evaluator for one stage-2 directory entry.
  Assumes inputs are stable in the same clock domain; purely combinational.
*/
`timescale 1ns/1ps
`include "s2de_regs.vh"

module s2de_perm
(
  input wire [`S2DE_ENTRY_W-1:0] entry_i,
  input wire io_perm_en_i,
  input wire zero_len_read_support_i,
  input wire zero_len_i,
  output reg read_ok_o,
  output reg write_ok_o
);

  reg wr_bit;
  reg rd_bit;

  // ==========================================
  // Permission select
  always @*
  begin
    wr_bit = 1'h0;
    rd_bit = 1'h0;
    if (io_perm_en_i)
    begin
      wr_bit = entry_i[`S2DE_BIT_IO_WRITE];
      rd_bit = entry_i[`S2DE_BIT_IO_READ];
    end
    else
    begin
      wr_bit = entry_i[`S2DE_BIT_WRITE];
      rd_bit = entry_i[`S2DE_BIT_READ];
    end
    write_ok_o = wr_bit;
    // Zero-length reads pass on write permission alone
    if (zero_len_read_support_i && zero_len_i && wr_bit)
    begin
      read_ok_o = 1'h1;
    end
    else
    begin
      read_ok_o = rd_bit;
    end
  end

endmodule

/* verification/s2de_assertions.sv */
/* Checker on s2de_decode ports.
   Assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
module s2de_chk #(parameter HOST_ADDR_WIDTH=46)(input wire clk_sys_i,resetn_i,
  entry_valid_i,io_perm_en_i,zero_len_read_support_i,access_dirty_track_en_i,
  zero_len_i,result_valid_o,points_to_table_o,large_page_flag_o,read_ok_o,
  write_ok_o,accessed_o,malformed_o,input wire [63:0] stage2_dir_entry_i,
  input wire [51:0] next_table_addr_o);
  wire [63:0] e=stage2_dir_entry_i;
  wire [51:0] lo=(52'h1<<HOST_ADDR_WIDTH)-1;
  wire z=zero_len_i&zero_len_read_support_i;
  wire io=io_perm_en_i;
  wire bad=e[11]|(|(e[51:0]&~lo))|(e[62]&!io);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  pulse_once_a: assert property (result_valid_o==$past(entry_valid_i))
    else $error("valid pulse wrong");
  table_ptr_a: assert property (entry_valid_i|=>
    points_to_table_o==!$past(e[7])&&large_page_flag_o==$past(e[7])) else $error("ptr");
  addr_take_a: assert property (entry_valid_i|=>
    next_table_addr_o==($past(e[51:0])&lo&~52'hfff)) else $error("addr");
  addr_hold_a: assert property (!entry_valid_i|=>$stable(next_table_addr_o))
    else $error("addr moved");
  used_bit_a: assert property (entry_valid_i|=>
    accessed_o==$past(e[8]&access_dirty_track_en_i)) else $error("accessed");
  rsvd_flag_a: assert property (entry_valid_i|=>malformed_o==$past(bad))
    else $error("malformed");
  write_perm_a: assert property (entry_valid_i|=>
    write_ok_o==(!$past(bad)&&$past(io?e[62]:e[1]))) else $error("write");
  read_perm_a: assert property (entry_valid_i|=>
    read_ok_o==(!$past(bad)&&$past(io?e[61]|z&e[62]:e[0]|z&e[1]))) else $error("read");
endmodule
bind s2de_decode s2de_chk #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) chk_u(
  .clk_sys_i(clk_sys_i),.resetn_i(resetn_i),.entry_valid_i(entry_valid_i),
  .io_perm_en_i(io_perm_en_i),.zero_len_read_support_i(zero_len_read_support_i),
  .access_dirty_track_en_i(access_dirty_track_en_i),.zero_len_i(zero_len_i),
  .result_valid_o(result_valid_o),.points_to_table_o(points_to_table_o),
  .large_page_flag_o(large_page_flag_o),.read_ok_o(read_ok_o),.write_ok_o(write_ok_o),
  .accessed_o(accessed_o),.malformed_o(malformed_o),
  .stage2_dir_entry_i(stage2_dir_entry_i),.next_table_addr_o(next_table_addr_o));

/* verification/s2de_walker.sv */
/* Page-walk model that hands entries over.
   Assumes the bench calls its tasks; drives on the falling edge. */
`timescale 1ns/1ps
module s2de_walker(input wire clk_sys_i,output logic vld_o,output logic [63:0] ent_o,
  output logic [3:0] mode_o);
  initial {vld_o,ent_o,mode_o}=0;
  // Mode is io, zero-length support, tracking, zero length
  task put(input logic [63:0] d,input logic [3:0] m);
    @(negedge clk_sys_i);
    {vld_o,ent_o,mode_o}={1'b1,d,m};
  endtask
  // Released word inverted so stale data never looks valid
  task idle();
    @(negedge clk_sys_i);
    {vld_o,ent_o}={1'b0,~ent_o};
  endtask
endmodule

/* verification/tb_second_stage_dir_entry_decode.sv */
/* Bench for s2de_decode with walker model.
   Assumes checker bound to the design. */
`timescale 1ns/1ps
module tb_second_stage_dir_entry_decode;
  localparam AW=40;
  localparam logic [51:0] M=((52'h1<<AW)-1)&~52'hfff;
  logic clk_sys_i=0;
  logic resetn_i=0;
  logic vld;
  logic [63:0] ent;
  logic [3:0] md;
  wire rv,pt,lp,rd,wr,ac,ml;
  wire [51:0] ad;
  int num_errors=0;
  int checks_done=0;
  int cyc=0;
  // Entry, mode, flags pt lp rd wr ac ml
  logic [73:0] tc[9]='{{64'h00ab_cdef_f103,4'h2,6'h2e},
    {64'h00ab_cdef_f103,4'h8,6'h20},
    {64'h6000_0000_0000_0080,4'ha,6'h1c},
    {64'h4000_0000_0000_0003,4'h0,6'h21},
    {64'h0000_0000_0000_0803,4'h0,6'h21},
    {64'h0000_0100_0000_0003,4'h0,6'h21},
    {64'h2,4'h5,6'h2c},
    {64'h2,4'h1,6'h24},
    {64'h4000_0000_0000_0000,4'hd,6'h2c}};
  always #2.5 clk_sys_i=~clk_sys_i;
  s2de_walker wlk_u(.clk_sys_i(clk_sys_i),.vld_o(vld),.ent_o(ent),.mode_o(md));
  s2de_decode #(.HOST_ADDR_WIDTH(AW)) dut_u(.clk_sys_i(clk_sys_i),.resetn_i(resetn_i),
    .entry_valid_i(vld),.stage2_dir_entry_i(ent),.io_perm_en_i(md[3]),
    .zero_len_read_support_i(md[2]),.access_dirty_track_en_i(md[1]),.zero_len_i(md[0]),
    .result_valid_o(rv),.next_table_addr_o(ad),.points_to_table_o(pt),
    .large_page_flag_o(lp),.read_ok_o(rd),.write_ok_o(wr),.accessed_o(ac),
    .malformed_o(ml));
  task cmp(input string n,input logic [51:0] x,input logic [51:0] g);
    checks_done++;
    if (g!==x)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h",n,x,g);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d",checks_done,num_errors);
    if (num_errors==0&&checks_done>0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run needs under 100 cycles
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc==2000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i) resetn_i=1;
    foreach (tc[i])
    begin
      wlk_u.put(tc[i][73:10],tc[i][9:6]);
      @(posedge clk_sys_i) #1;
      cmp("valid",1,rv);
      cmp("addr",tc[i][61:10]&M,ad);
      cmp("flags",tc[i][5:0],{pt,lp,rd,wr,ac,ml});
      wlk_u.idle();
      @(posedge clk_sys_i) #1;
      cmp("idle",0,rv);
      cmp("addr hold",tc[i][61:10]&M,ad);
      cmp("flags hold",tc[i][5:0],{pt,lp,rd,wr,ac,ml});
      $display("test %0d done",i);
    end
    print_verdict();
  end
endmodule
